// *** verification/count_pin_model.sv ***
// Model of the signals that reach the count pins from outside
`timescale 1ns/100ps

module count_pin_model (
    // Clock
    input wire logic clock,
    // Count pins
    output logic counter_input_zero,
    output logic counter_input_one,
    output logic phase_input_pin
);
    // ------------------------------------------------------------
    // Pin levels
    // ------------------------------------------------------------
    // Pins are driven lines, low until the bench moves them
    initial begin
        counter_input_zero = 1'b0;
        counter_input_one = 1'b0;
        phase_input_pin = 1'b0;
    end

    // Sets one pin just after an edge, then holds it six clocks, since
    // pulses shorter than the synchroniser depth may be lost
    task automatic drive(input int idx, input logic lvl);
        @(posedge clock);
        #1;
        case (idx)
            0: counter_input_zero = lvl;
            1: counter_input_one = lvl;
            default: phase_input_pin = lvl;
        endcase
        repeat (6) @(posedge clock);
    endtask

    // One full high pulse on a pin
    task automatic pulse(input int idx);
        drive(idx, 1'b1);
        drive(idx, 1'b0);
    endtask
endmodule // count_pin_model

// *** verification/dual_16bit_timer_unit_tb.sv ***
// Self-checking bench of the dual 16-bit timer unit
`timescale 1ns/100ps

module dual_16bit_timer_unit_tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    timer_xy_pkg::cpu_req_t cpu_req;
    logic [7:0] rd_data;
    logic [7:0] x_mode;
    logic [7:0] y_mode;
    logic pin0, pin1, phase;
    logic timer_x_irq, timer_y_irq, counter_input_zero_irq;
    logic [15:0] v, v2;
    int n_mismatch = 0;
    int num_checks = 0;
    int nx = 0, nc0 = 0, ny = 0, cyc = 0, last_x = 0, t_a, sel;

    always #12.5 clock = ~clock;

    dual_16bit_timer_unit DUT (
        .clock(clock), .reset_n(reset_n), .cpu_req(cpu_req),
        .rd_data(rd_data), .timer_x_mode_register(x_mode),
        .timer_y_mode_register(y_mode), .counter_input_zero(pin0),
        .counter_input_one(pin1), .phase_input_pin(phase),
        .timer_x_irq(timer_x_irq), .timer_y_irq(timer_y_irq),
        .counter_input_zero_irq(counter_input_zero_irq)
    );

    count_pin_model pins (
        .clock(clock), .counter_input_zero(pin0),
        .counter_input_one(pin1), .phase_input_pin(phase)
    );

    // Irq pulses last one cycle, so they are counted at every edge
    always @(posedge clock) begin
        cyc++;
        if (timer_x_irq === 1'b1) begin
            nx++;
            last_x = cyc;
        end
        if (counter_input_zero_irq === 1'b1) nc0++;
        if (timer_y_irq === 1'b1) ny++;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check16(input string name, input logic [15:0] exp,
                           input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_cnt(input string name, input int exp, input int got);
        num_checks++;
        if (got != exp) begin
            n_mismatch++;
            $display("ERROR %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    // One byte access; the idle cycle after it keeps strobes one-shot
    task automatic op(input logic wr, input logic sel_y, input logic high,
                      input logic [7:0] data, output logic [7:0] q);
        @(posedge clock);
        #1;
        cpu_req = {wr, ~wr, sel_y, high, data};
        @(posedge clock);
        #1;
        q = rd_data;
        cpu_req = '0;
    endtask

    // Low byte first, then high byte
    task automatic wr16(input logic sel_y, input logic [15:0] val);
        logic [7:0] q;
        op(1'b1, sel_y, 1'b0, val[7:0], q);
        op(1'b1, sel_y, 1'b1, val[15:8], q);
    endtask

    // High byte first, which freezes the low byte for the second read
    task automatic rd16(input logic sel_y, output logic [15:0] val);
        op(1'b0, sel_y, 1'b1, 8'h00, val[15:8]);
        op(1'b0, sel_y, 1'b0, 8'h00, val[7:0]);
    endtask

    task automatic modes(input logic [7:0] xm, input logic [7:0] ym);
        @(posedge clock);
        #1;
        x_mode = xm;
        y_mode = ym;
    endtask

    // Bounded wait for the next timer X irq pulse
    task automatic wait_x_irq(input int max);
        int n0;
        n0 = nx;
        for (int i = 0; i < max && nx == n0; i++) @(posedge clock);
        check_cnt("x irq seen", 1, (nx != n0) ? 1 : 0);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    // Tests need under 15000 cycles; the limit leaves ample margin
    initial begin
        #(40000 * 25);
        n_mismatch++;
        $display("ERROR watchdog expected done seen hang");
        print_verdict();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        cpu_req = '0;
        x_mode = 8'h80;
        y_mode = 8'h80;
        repeat (16) @(posedge clock);
        #1;
        reset_n = 1'b1;
        repeat (3) @(posedge clock);
        // Byte order access while both timers are stopped
        modes(8'h8A, 8'h80);
        wr16(1'b0, 16'h0002);
        rd16(1'b0, v);
        check16("x after write", 16'h0002, v);
        rd16(1'b1, v);
        check16("y latch only", 16'hFFFF, v);
        pins.pulse(0);
        rd16(1'b0, v);
        check16("x stopped", 16'h0002, v);
        $display("test access done");
        // Event counting, rising then falling polarity, through an underflow
        modes(8'h0A, 8'h80);
        pins.pulse(0);
        pins.pulse(0);
        rd16(1'b0, v);
        check16("x event rise", 16'h0000, v);
        check_cnt("x irq before", 0, nx);
        pins.pulse(0);
        check_cnt("x irq underflow", 1, nx);
        rd16(1'b0, v);
        check16("x reload", 16'h0002, v);
        modes(8'h02, 8'h41);
        pins.drive(0, 1'b1);
        rd16(1'b0, v);
        check16("x fall pol no rise", 16'h0002, v);
        pins.drive(0, 1'b0);
        rd16(1'b0, v);
        check16("x fall pol", 16'h0001, v);
        pins.pulse(1);
        rd16(1'b1, v);
        check16("y event", 16'hFFFE, v);
        modes(8'h82, 8'h81);
        pins.pulse(1);
        rd16(1'b1, v);
        check16("y stopped", 16'hFFFE, v);
        check_cnt("y irq none", 0, ny);
        $display("test event done");
        // Quadrature steps forward, back, below zero and above all ones
        modes(8'h01, 8'h80);
        wr16(1'b0, 16'h0000);
        pins.drive(2, 1'b1);
        pins.drive(1 - 1, 1'b1);
        pins.drive(2, 1'b0);
        pins.drive(0, 1'b0);
        rd16(1'b0, v);
        check16("biphase up", 16'h0004, v);
        pins.drive(0, 1'b1);
        pins.drive(2, 1'b1);
        pins.drive(0, 1'b0);
        pins.drive(2, 1'b0);
        rd16(1'b0, v);
        check16("biphase down", 16'h0000, v);
        nx = 0;
        pins.drive(0, 1'b1);
        rd16(1'b0, v);
        check16("biphase under", 16'hFFFF, v);
        pins.drive(0, 1'b0);
        rd16(1'b0, v);
        check16("biphase over", 16'h0000, v);
        check_cnt("biphase irqs", 2, nx);
        $display("test biphase done");
        // Deferred reload, then underflow spacing for each divider
        modes(8'h80, 8'h80);
        wr16(1'b0, 16'h0003);
        modes(8'h84, 8'h80);
        wr16(1'b0, 16'h0009);
        rd16(1'b0, v);
        check16("deferred reload", 16'h0003, v);
        for (sel = 0; sel < 4; sel++) begin
            modes(8'h04, 8'h80 | 8'(sel << 2));
            wait_x_irq(2000);
            wait_x_irq(2000);
            t_a = last_x;
            wait_x_irq(2000);
            check_cnt("period", 10 * (2 << (2 * sel)), last_x - t_a);
        end
        $display("test timer done");
        // Pulse width: count while high, hold while low
        modes(8'h8B, 8'h80);
        wr16(1'b0, 16'h00FF);
        modes(8'h0B, 8'h80);
        nc0 = 0;
        repeat (6) pins.drive(0, 1'b1);
        pins.drive(0, 1'b0);
        check_cnt("width end irq", 1, nc0);
        rd16(1'b0, v);
        check_cnt("width counted", 1, (v < 16'h00FF) ? 1 : 0);
        repeat (20) @(posedge clock);
        rd16(1'b0, v2);
        check16("width idle hold", v, v2);
        $display("test width done");
        print_verdict();
    end
endmodule // dual_16bit_timer_unit_tb

// *** verilog/dual_16bit_timer_unit.sv ***
// Two 16-bit counters, down except timer X in bi-phase, with reload latches, byte access and pin modes
`timescale 1ns/100ps
`include "timer_xy_regs.svh"

module dual_16bit_timer_unit (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Byte access from the core
    input wire timer_xy_pkg::cpu_req_t cpu_req,
    output logic [7:0] rd_data,
    // Mode registers held by the core
    input wire logic [7:0] timer_x_mode_register,
    input wire logic [7:0] timer_y_mode_register,
    // Count pins
    input wire logic counter_input_zero,
    input wire logic counter_input_one,
    input wire logic phase_input_pin,
    // Interrupt request pulses
    output logic timer_x_irq,
    output logic timer_y_irq,
    output logic counter_input_zero_irq
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------

    // Divider tick from the free prescaler: ratios 2, 8, 32 and 128
    function automatic logic div_tick(input logic [7:0] p,
                                      input logic [1:0] sel);
        logic t;
        t = 1'b0;
        unique case (sel)
            2'h0: t = (p[0] == 1'h1);
            2'h1: t = (p[2:0] == 3'h7);
            2'h2: t = (p[4:0] == 5'h1F);
            2'h3: t = (p[6:0] == 7'h7F);
        endcase
        return t;
    endfunction

    // One count step; bit 16 flags an underflow or overflow
    function automatic logic [16:0] step(input logic [15:0] c,
                                         input logic up,
                                         input logic dn,
                                         input logic reload,
                                         input logic [15:0] lat);
        logic [16:0] r;
        r = {1'b0, c};
        if (dn) begin
            if (c == 16'h0000) begin
                r = {1'b1, reload ? lat : 16'hFFFF};
            end else begin
                r = {1'b0, c - 16'h0001};
            end
        end else if (up) begin
            if (c == 16'hFFFF) begin
                r = {1'b1, 16'h0000};
            end else begin
                r = {1'b0, c + 16'h0001};
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------

    logic [1:0] rst_q;
    logic rst_n;
    assign rst_n = rst_q[1];

    // Release reset through two flip-flops
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end

    // Pins: 0 counter zero, 1 counter one, 2 phase
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_s3;
    logic [2:0] pin_f;
    wire [2:0] pins = {phase_input_pin, counter_input_one,
                       counter_input_zero};
    // A change counts only once stages two and three agree
    wire [2:0] agree = ~(pin_s2 ^ pin_s3);
    wire [2:0] edge_p = agree & (pin_s3 ^ pin_f);
    wire [2:0] rise = edge_p & pin_s3;
    wire [2:0] fall = edge_p & ~pin_s3;

    // Three-stage capture; stage one feeds stage two only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
            pin_s3 <= 3'h0;
            pin_f <= 3'h0;
        end else begin
            pin_s1 <= pins;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_f <= (agree & pin_s3) | (~agree & pin_f);
        end
    end

    // ------------------------------------------------------------
    // Prescaler and mode decode
    // ------------------------------------------------------------

    logic [7:0] pre;

    // Free running; divider taps come from its low bits
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pre <= 8'h00;
        end else begin
            pre <= pre + 8'h01;
        end
    end

    timer_xy_pkg::x_mode_t x_mode;
    timer_xy_pkg::y_mode_t y_mode;
    assign x_mode = timer_xy_pkg::x_mode_t'(
        timer_x_mode_register[`TXM_MODE_HI:`TXM_MODE_LO]);
    assign y_mode = timer_xy_pkg::y_mode_t'(
        timer_y_mode_register[`TYM_MODE_HI:`TYM_MODE_LO]);
    wire x_run = ~timer_x_mode_register[`TXM_STOP];
    wire y_run = ~timer_y_mode_register[`TYM_STOP];
    wire x_wc = timer_x_mode_register[`TXM_WRITE_CTRL];
    wire pol0 = timer_x_mode_register[`TXM_COUNTER_INPUT_ZERO_POL];
    wire pol1 = timer_y_mode_register[`TYM_COUNTER_INPUT_ONE_POL];
    // Both divider ratios are chosen in the timer Y mode register
    wire x_div = div_tick(pre,
        timer_y_mode_register[`TYM_XDIV_HI:`TYM_XDIV_LO]);
    wire y_div = div_tick(pre,
        timer_y_mode_register[`TYM_YDIV_HI:`TYM_YDIV_LO]);

    // ------------------------------------------------------------
    // Count events
    // ------------------------------------------------------------

    // Polarity 1 counts rising edges, 0 falling edges
    wire ev0 = pol0 ? rise[0] : fall[0];
    wire ev1 = pol1 ? rise[1] : fall[1];
    // Pulse width counts only while the pin sits at its active level
    wire pw_active = (pin_f[0] == pol0);
    // Quadrature direction; a phase edge wins if both pins move at once
    wire ph_up = (rise[2] & ~pin_f[0]) | (fall[2] & pin_f[0]);
    wire ph_dn = edge_p[2] & ~ph_up;
    wire c_dn = (rise[0] & ~pin_f[2]) | (fall[0] & pin_f[2]);
    wire c_up = edge_p[0] & ~c_dn & ~edge_p[2];
    wire bi_up = ph_up | c_up;
    wire bi_dn = ph_dn | (c_dn & ~edge_p[2]);

    logic x_dn;
    logic x_up;
    logic y_dn;
    // Timer X source by mode
    always_comb begin
        x_dn = 1'b0;
        x_up = 1'b0;
        unique case (x_mode)
            timer_xy_pkg::X_TIMER: x_dn = x_div;
            timer_xy_pkg::X_BIPHASE: begin
                x_dn = bi_dn;
                x_up = bi_up;
            end
            timer_xy_pkg::X_EVENT: x_dn = ev0;
            timer_xy_pkg::X_PULSE_WIDTH: x_dn = x_div & pw_active;
        endcase
        x_dn = x_dn & x_run;
        x_up = x_up & x_run;
    end

    // Timer Y source; the period modes are not built and hold the count
    always_comb begin
        y_dn = 1'b0;
        unique case (y_mode)
            timer_xy_pkg::Y_TIMER: y_dn = y_div;
            timer_xy_pkg::Y_EVENT: y_dn = ev1;
            timer_xy_pkg::Y_PERIOD: y_dn = 1'b0;
            timer_xy_pkg::Y_HL_WIDTH: y_dn = 1'b0;
        endcase
        y_dn = y_dn & y_run;
    end

    // ------------------------------------------------------------
    // Byte access decode
    // ------------------------------------------------------------

    wire x_sel = ~cpu_req.sel_y;
    wire x_wr_lo = cpu_req.wr & x_sel & ~cpu_req.high;
    wire x_wr_hi = cpu_req.wr & x_sel & cpu_req.high;
    wire y_wr_lo = cpu_req.wr & cpu_req.sel_y & ~cpu_req.high;
    wire y_wr_hi = cpu_req.wr & cpu_req.sel_y & cpu_req.high;
    wire x_rd_hi = cpu_req.rd & x_sel & cpu_req.high;
    wire y_rd_hi = cpu_req.rd & cpu_req.sel_y & cpu_req.high;
    wire x_load = x_wr_hi & ~x_wc;

    logic [15:0] x_cnt;
    logic [15:0] y_cnt;
    logic [15:0] x_latch;
    logic [15:0] y_latch;
    logic [7:0] x_wtmp;
    logic [7:0] y_wtmp;
    logic [7:0] x_snap_lo;
    logic [7:0] y_snap_lo;

    // Bi-phase wraps instead of reloading so position stays continuous
    wire [15:0] x_new_latch = {cpu_req.data, x_wtmp};
    // A latch written in this cycle is what an underflow reloads
    wire [15:0] next_x_latch = x_wr_hi ? x_new_latch : x_latch;
    wire [15:0] next_y_latch = y_wr_hi ? {cpu_req.data, y_wtmp}
                                       : y_latch;
    wire [16:0] x_step = step(x_cnt, x_up, x_dn,
        x_mode != timer_xy_pkg::X_BIPHASE, next_x_latch);
    wire [16:0] y_step = step(y_cnt, 1'b0, y_dn, 1'b1, next_y_latch);
    wire [15:0] next_x_cnt = x_load ? x_new_latch : x_step[15:0];
    wire pw_end = (x_mode == timer_xy_pkg::X_PULSE_WIDTH) &
                  edge_p[0] & (pin_s3[0] != pol0);

    // ------------------------------------------------------------
    // Latches and write holding registers
    // ------------------------------------------------------------

    // Low byte waits until its high byte arrives
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            x_wtmp <= `BYTE_RESET;
            y_wtmp <= `BYTE_RESET;
            x_latch <= `LATCH_RESET;
            y_latch <= `LATCH_RESET;
        end else begin
            x_wtmp <= x_wr_lo ? cpu_req.data : x_wtmp;
            y_wtmp <= y_wr_lo ? cpu_req.data : y_wtmp;
            x_latch <= next_x_latch;
            y_latch <= next_y_latch;
        end
    end

    // ------------------------------------------------------------
    // Counters and interrupt pulses
    // ------------------------------------------------------------

    // Counters step; a direct load on timer X overrides the count
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            x_cnt <= `COUNT_RESET;
            y_cnt <= `COUNT_RESET;
            timer_x_irq <= 1'b0;
            timer_y_irq <= 1'b0;
            counter_input_zero_irq <= 1'b0;
        end else begin
            x_cnt <= next_x_cnt;
            y_cnt <= y_step[15:0];
            timer_x_irq <= x_step[16] & ~x_load;
            timer_y_irq <= y_step[16];
            counter_input_zero_irq <= pw_end;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------

    // High read snapshots the low byte; data appears one cycle later
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            x_snap_lo <= `BYTE_RESET;
            y_snap_lo <= `BYTE_RESET;
            rd_data <= `BYTE_RESET;
        end else begin
            x_snap_lo <= x_rd_hi ? x_cnt[7:0] : x_snap_lo;
            y_snap_lo <= y_rd_hi ? y_cnt[7:0] : y_snap_lo;
            if (cpu_req.rd) begin
                unique case ({cpu_req.sel_y, cpu_req.high})
                    2'h0: rd_data <= x_snap_lo;
                    2'h1: rd_data <= x_cnt[15:8];
                    2'h2: rd_data <= y_snap_lo;
                    2'h3: rd_data <= y_cnt[15:8];
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_x_write_now: assert property (x_load |=>
        x_cnt == {$past(cpu_req.data), $past(x_wtmp)})
        else $error("timer X direct load missed");
    a_x_write_later: assert property (
        x_wr_hi & x_wc & ~x_dn & ~x_up |=> x_cnt == $past(x_cnt))
        else $error("timer X counter changed on deferred write");
    a_latch_pair: assert property (
        x_wr_lo ##1 ~x_wr_lo ##1 x_wr_hi |=>
        x_latch == {$past(cpu_req.data), $past(cpu_req.data, 3)})
        else $error("timer X latch bytes not paired");
    a_read_coherent: assert property (
        x_rd_hi ##1 ~x_rd_hi ##1 (cpu_req.rd & ~cpu_req.sel_y &
        ~cpu_req.high) |=> rd_data == $past(x_cnt[7:0], 3))
        else $error("timer X low read not from snapshot");
    a_stop_hold: assert property (
        ~x_run & ~x_load |=> x_cnt == $past(x_cnt) && !timer_x_irq)
        else $error("stopped timer X moved");
    a_x_underflow: assert property (
        x_dn & (x_cnt == 16'h0000) & ~x_load &
        (x_mode != timer_xy_pkg::X_BIPHASE)
        |=> timer_x_irq && x_cnt == $past(next_x_latch))
        else $error("timer X underflow without reload");
    a_y_underflow: assert property (
        y_dn & (y_cnt == 16'h0000) |=>
        timer_y_irq && y_cnt == $past(next_y_latch))
        else $error("timer Y underflow without reload");
    a_bi_overflow: assert property (
        x_up & (x_cnt == 16'hFFFF) & ~x_load |=>
        timer_x_irq && x_cnt == 16'h0000)
        else $error("bi-phase overflow not flagged");
    a_bi_up: assert property (
        x_up & (x_cnt != 16'hFFFF) & ~x_load |=>
        x_cnt == $past(x_cnt) + 16'h0001)
        else $error("bi-phase up count wrong");
    a_pw_end: assert property (pw_end |=> counter_input_zero_irq ##1 !counter_input_zero_irq)
        else $error("pulse width end not flagged once");

endmodule // dual_16bit_timer_unit

// *** verilog/timer_xy_pkg.sv ***
// Types shared by the dual 16-bit timer unit
package timer_xy_pkg;
    // Timer X operating modes
    typedef enum logic [1:0] {
        X_TIMER = 2'h0,
        X_BIPHASE = 2'h1,
        X_EVENT = 2'h2,
        X_PULSE_WIDTH = 2'h3
    } x_mode_t;
    // Timer Y operating modes; codes 2 and 3 are the period modes
    typedef enum logic [1:0] {
        Y_TIMER = 2'h0,
        Y_EVENT = 2'h1,
        Y_PERIOD = 2'h2,
        Y_HL_WIDTH = 2'h3
    } y_mode_t;
    // One byte access from the processor core
    typedef struct packed {
        logic wr;
        logic rd;
        logic sel_y;
        logic high;
        logic [7:0] data;
    } cpu_req_t;
endpackage

// *** verilog/timer_xy_regs.svh ***
// Bit positions and reset values of the dual 16-bit timer unit
`ifndef TIMER_XY_REGS_SVH
`define TIMER_XY_REGS_SVH
// Timer X mode register fields
`define TXM_MODE_HI 1
`define TXM_MODE_LO 0
`define TXM_WRITE_CTRL 2
`define TXM_COUNTER_INPUT_ZERO_POL 3
`define TXM_STOP 7
// Timer Y mode register fields
`define TYM_MODE_HI 1
`define TYM_MODE_LO 0
`define TYM_XDIV_HI 3
`define TYM_XDIV_LO 2
`define TYM_YDIV_HI 5
`define TYM_YDIV_LO 4
`define TYM_COUNTER_INPUT_ONE_POL 6
`define TYM_STOP 7
// Reset values
`define COUNT_RESET 16'hFFFF
`define LATCH_RESET 16'hFFFF
`define BYTE_RESET 8'h00
`endif
